// file: rtl/pal_pkg.sv
// Constants and carriers for the parameter access lock.
// Assumes parameter numbers and values travel as 16-bit binary words.
package pal_pkg;

  // Parameter numbers handled by the lock itself
  localparam logic [15:0] PNUM_DISP_SEL = 16'h00a0;
  localparam logic [15:0] PNUM_LOCK_LVL = 16'h0128;
  localparam logic [15:0] PNUM_PASSWORD = 16'h0129;
  localparam logic [15:0] PNUM_CONTRAST = 16'h03df;

  // Reset values and special settings
  localparam logic [15:0] DISP_SEL_RST = 16'h0000;
  localparam logic [15:0] DISP_EXTENDED = 16'h0000;
  localparam logic [15:0] DISP_SIMPLE = 16'h270f;
  localparam logic [15:0] NO_LOCK = 16'h270f;
  localparam logic [15:0] LOCK_LVL_RST = 16'h270f;
  localparam logic [15:0] PASSWORD_RST = 16'h270f;
  localparam logic [15:0] PW_MIN = 16'h03e8;
  localparam logic [15:0] PW_MAX = 16'h270e;
  localparam logic [15:0] LVL_LO_MIN = 16'h0001;
  localparam logic [15:0] LVL_LO_MAX = 16'h0006;
  localparam logic [15:0] LVL_HI_MIN = 16'h0065;
  localparam logic [15:0] LVL_HI_MAX = 16'h006a;
  localparam logic [15:0] LVL_HI_OFS = 16'h0064;
  localparam logic [15:0] CSS_NET = 16'h0002;
  localparam logic [1:0] WP_INHIBIT = 2'h1;
  localparam logic [2:0] FAIL_MAX = 3'h5;

  // Restriction masks, bit n set when level n permits the access
  localparam logic [7:0] LOCAL_RD_MASK = 8'h4e;
  localparam logic [7:0] LOCAL_WR_MASK = 8'h48;
  localparam logic [7:0] SERIAL_RD_MASK = 8'h2e;
  localparam logic [7:0] SERIAL_WR_MASK = 8'h24;

  typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_CLEAR, OP_ALL_CLEAR, OP_COPY} op_e;

  // Access request from panel or serial host
  typedef struct packed {
    op_e op;
    logic serial;
    logic simple;
    logic wp_exempt;
    logic [15:0] pnum;
    logic [15:0] wdata;
  } req_s;

  // Answer to a request
  typedef struct packed {
    logic ok;
    logic lock_refused;
    logic [15:0] rdata;
  } resp_s;

  // Write channel towards the parameter memory
  typedef struct packed {
    logic en;
    logic [15:0] addr;
    logic [15:0] data;
  } mem_wr_s;

endpackage

// file: rtl/sync_two_ff.sv
// Two-flop synchroniser for level inputs arriving from pins.
// Assumes the inputs are slow levels; no pulse is guaranteed to pass.
`timescale 1ns/1ps
module sync_two_ff #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  ////////////////////////////////////////////////////////////////////////
  // First stage is read only by the second
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// file: rtl/parameter_access_lock.sv
// Access guard between panel/serial requests and the parameter memory.
// Assumes requests and memory on core_clk; run and unit-present are pins.
//
// Behaviour
// - Display select hides extended parameters locally
// - Serial reads ignore display unless source 2
// - Lock level accepts 9999, 1-6, 101-106
// - Local access table per lock level
// - Serial access table per lock level
// - Display hiding still refuses permitted reads
// - Write protect still refuses permitted writes
// - Password 1000-9998 written registers the lock
// - No lock: password write refused, reads 9999
// - Registered password reads back 0 to 5
// - High levels report failed unlock count
// - Matching password unlocks, mismatch flags error
// - Five failures at high levels block unlocking
// - All clear removes lock, resets settings
// - All clear refused while drive outputs voltage
// - Lock blocks level, clear, copy writes
// - Password refusals leave lock indication as is
// - Internal memory updates always pass
// - Contrast open when parameter unit present
// - Blocked local writes disable easy mode switch
// - Display select and lock level set only in extended display
// - Write protect 1 refuses writes except list and own parameters
`timescale 1ns/1ps
module parameter_access_lock (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Requests from local panel and serial host
  input wire logic req_valid,
  input wire pal_pkg::req_s req,
  output logic req_ready,
  output logic resp_valid,
  output pal_pkg::resp_s resp,
  // Settings held in the parameter memory
  input wire logic [1:0] write_protect_select,
  input wire logic [15:0] local_command_source_select,
  // Pins
  input wire logic drive_running,
  input wire logic param_unit_present,
  // Internal updates from the drive itself
  input wire pal_pkg::mem_wr_s int_wr,
  // Parameter memory side
  output pal_pkg::mem_wr_s mem_wr,
  output logic mem_rd_en,
  output logic [15:0] mem_raddr,
  input wire logic [15:0] mem_rdata,
  output logic mem_clear,
  output logic mem_all_clear,
  output logic mem_copy,
  // Status
  output logic lock_indication,
  output logic unlock_error,
  output logic easy_mode_switch_en,
  output logic password_registered,
  output logic [2:0] fail_count
);

  typedef enum logic [1:0] {ST_IDLE, ST_MRD, ST_MWAIT} state_e;

  state_e state_q;
  logic [15:0] disp_q;
  logic [15:0] lvl_q;
  logic [15:0] pw_q;
  logic pw_set_q;
  logic [2:0] fail_q;
  logic running_s;
  logic unit_s;
  logic take;
  logic [15:0] lvl_off;
  logic lvl_hi;
  logic [2:0] base;
  logic restr;
  logic rd_ok;
  logic wr_ok;
  logic lwr_ok;
  logic contrast_ok;
  logic simple;
  logic hidden;
  logic own;
  logic wp_on;
  logic wp_block;
  logic grant;
  logic lock_ref;
  logic mem_read;
  logic pw_match;
  logic pw_blocked;
  logic unlock_err_c;
  logic lvl_valid;
  logic pw_valid;
  logic [15:0] pw_read;
  logic [15:0] own_rdata;

  ////////////////////////////////////////////////////////////////////////
  // Pin levels cross into core_clk
  sync_two_ff #(.W(2)) pin_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in({drive_running, param_unit_present}),
    .sync_out({running_s, unit_s})
  );

  // Internal updates own the write channel, so a request waits for them
  assign take = req_valid && req_ready && !int_wr.en;

  ////////////////////////////////////////////////////////////////////////
  // Level decode and access permissions
  assign lvl_off = lvl_q - pal_pkg::LVL_HI_OFS;
  assign lvl_hi = lvl_q >= pal_pkg::LVL_HI_MIN && lvl_q <= pal_pkg::LVL_HI_MAX;
  assign base = lvl_hi ? lvl_off[2:0] : lvl_q[2:0];
  assign restr = pw_set_q && lvl_q != pal_pkg::NO_LOCK;

  always_comb begin
    rd_ok = !restr || pal_pkg::LOCAL_RD_MASK[base];
    wr_ok = !restr || pal_pkg::LOCAL_WR_MASK[base];
    if (req.serial) begin
      rd_ok = !restr || pal_pkg::SERIAL_RD_MASK[base];
      wr_ok = !restr || pal_pkg::SERIAL_WR_MASK[base];
    end
  end

  assign lwr_ok = !restr || pal_pkg::LOCAL_WR_MASK[base];
  assign contrast_ok = req.pnum == pal_pkg::PNUM_CONTRAST && unit_s;
  assign simple = req.simple || contrast_ok;
  assign hidden = disp_q == pal_pkg::DISP_SIMPLE && !simple
                  && !(req.serial && local_command_source_select != pal_pkg::CSS_NET);
  assign own = req.pnum == pal_pkg::PNUM_DISP_SEL || req.pnum == pal_pkg::PNUM_LOCK_LVL
               || req.pnum == pal_pkg::PNUM_PASSWORD;
  assign wp_on = write_protect_select == pal_pkg::WP_INHIBIT;
  assign wp_block = wp_on && !req.wp_exempt && !own;

  assign lvl_valid = req.wdata == pal_pkg::NO_LOCK
                     || (req.wdata >= pal_pkg::LVL_LO_MIN && req.wdata <= pal_pkg::LVL_LO_MAX)
                     || (req.wdata >= pal_pkg::LVL_HI_MIN && req.wdata <= pal_pkg::LVL_HI_MAX);
  assign pw_valid = req.wdata >= pal_pkg::PW_MIN && req.wdata <= pal_pkg::PW_MAX;
  assign pw_match = req.wdata == pw_q;
  assign pw_blocked = lvl_hi && fail_q == pal_pkg::FAIL_MAX;

  ////////////////////////////////////////////////////////////////////////
  // Grant decision for the offered request
  always_comb begin
    grant = 1'b0;
    lock_ref = 1'b0;
    mem_read = 1'b0;
    case (req.op)
      pal_pkg::OP_READ: begin
        if (req.pnum == pal_pkg::PNUM_LOCK_LVL || req.pnum == pal_pkg::PNUM_PASSWORD) begin
          grant = !(hidden && lvl_q == pal_pkg::NO_LOCK);
        end else begin
          grant = !hidden && (rd_ok || contrast_ok);
          lock_ref = !hidden && !(rd_ok || contrast_ok);
          mem_read = grant && req.pnum != pal_pkg::PNUM_DISP_SEL;
        end
      end
      pal_pkg::OP_WRITE: begin
        if (req.pnum == pal_pkg::PNUM_DISP_SEL) begin
          grant = disp_q == pal_pkg::DISP_EXTENDED && wr_ok
                  && (req.wdata == pal_pkg::DISP_EXTENDED || req.wdata == pal_pkg::DISP_SIMPLE);
          lock_ref = !wr_ok;
        end else if (req.pnum == pal_pkg::PNUM_LOCK_LVL) begin
          grant = disp_q == pal_pkg::DISP_EXTENDED && !pw_set_q && lvl_valid;
          lock_ref = pw_set_q;
        end else if (req.pnum == pal_pkg::PNUM_PASSWORD) begin
          grant = lvl_q != pal_pkg::NO_LOCK && (pw_set_q || pw_valid);
        end else begin
          grant = !wp_block && (wr_ok || contrast_ok);
          lock_ref = !(wr_ok || contrast_ok);
        end
      end
      pal_pkg::OP_CLEAR: begin
        grant = !pw_set_q && !wp_on;
        lock_ref = pw_set_q;
      end
      pal_pkg::OP_COPY: begin
        grant = !pw_set_q;
        lock_ref = pw_set_q;
      end
      pal_pkg::OP_ALL_CLEAR: begin
        grant = !running_s && !wp_on;
      end
      default: begin
        grant = 1'b0;
      end
    endcase
  end

  assign unlock_err_c = take && req.op == pal_pkg::OP_WRITE && req.pnum == pal_pkg::PNUM_PASSWORD
                        && grant && pw_set_q && !pw_blocked && !pw_match;

  ////////////////////////////////////////////////////////////////////////
  // Read values of the parameters kept here
  always_comb begin
    pw_read = pal_pkg::NO_LOCK;
    if (restr) begin
      pw_read = lvl_hi ? {13'h0000, fail_q} : 16'h0000;
    end
    own_rdata = disp_q;
    if (req.pnum == pal_pkg::PNUM_LOCK_LVL) begin
      own_rdata = lvl_q;
    end else if (req.pnum == pal_pkg::PNUM_PASSWORD) begin
      own_rdata = pw_read;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: memory reads take two extra cycles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      req_ready <= 1'b1;
      mem_rd_en <= 1'b0;
      mem_raddr <= 16'h0000;
    end else begin
      mem_rd_en <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take && mem_read) begin
            state_q <= ST_MRD;
            req_ready <= 1'b0;
            mem_rd_en <= 1'b1;
            mem_raddr <= req.pnum;
          end
        end
        ST_MRD: begin
          state_q <= ST_MWAIT;
        end
        ST_MWAIT: begin
          state_q <= ST_IDLE;
          req_ready <= 1'b1;
        end
        default: begin
          state_q <= ST_IDLE;
          req_ready <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer: one cycle after take, or after the memory returns
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      resp_valid <= 1'b0;
      resp <= '0;
    end else begin
      resp_valid <= 1'b0;
      if (state_q == ST_MWAIT) begin
        resp_valid <= 1'b1;
        resp.rdata <= mem_rdata;
      end else if (take && !mem_read) begin
        resp_valid <= 1'b1;
        resp.ok <= grant && !unlock_err_c;
        resp.lock_refused <= lock_ref;
        resp.rdata <= (grant && req.op == pal_pkg::OP_READ) ? own_rdata : 16'h0000;
      end else if (take) begin
        resp.ok <= 1'b1;
        resp.lock_refused <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory commands; internal updates take the write channel first
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_wr <= '0;
      mem_clear <= 1'b0;
      mem_all_clear <= 1'b0;
      mem_copy <= 1'b0;
    end else begin
      mem_wr.en <= 1'b0;
      if (int_wr.en) begin
        mem_wr <= int_wr;
      end else if (take && grant && req.op == pal_pkg::OP_WRITE && !own) begin
        mem_wr.en <= 1'b1;
        mem_wr.addr <= req.pnum;
        mem_wr.data <= req.wdata;
      end
      mem_clear <= take && grant && req.op == pal_pkg::OP_CLEAR;
      mem_all_clear <= take && grant && req.op == pal_pkg::OP_ALL_CLEAR;
      mem_copy <= take && grant && req.op == pal_pkg::OP_COPY;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Display selection and lock level settings
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      disp_q <= pal_pkg::DISP_SEL_RST;
      lvl_q <= pal_pkg::LOCK_LVL_RST;
    end else if (take && grant && req.op == pal_pkg::OP_ALL_CLEAR) begin
      disp_q <= pal_pkg::DISP_SEL_RST;
      lvl_q <= pal_pkg::LOCK_LVL_RST;
    end else if (take && grant && req.op == pal_pkg::OP_WRITE) begin
      if (req.pnum == pal_pkg::PNUM_DISP_SEL) begin
        disp_q <= req.wdata;
      end
      if (req.pnum == pal_pkg::PNUM_LOCK_LVL) begin
        lvl_q <= req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Password register, lock state and failure count
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pw_q <= pal_pkg::PASSWORD_RST;
      pw_set_q <= 1'b0;
      fail_q <= 3'h0;
      unlock_error <= 1'b0;
    end else begin
      unlock_error <= unlock_err_c;
      if (take && grant && req.op == pal_pkg::OP_ALL_CLEAR) begin
        pw_q <= pal_pkg::PASSWORD_RST;
        pw_set_q <= 1'b0;
        fail_q <= 3'h0;
      end else if (take && grant && req.op == pal_pkg::OP_WRITE && req.pnum == pal_pkg::PNUM_PASSWORD) begin
        if (!pw_set_q) begin
          pw_q <= req.wdata;
          pw_set_q <= 1'b1;
          fail_q <= 3'h0;
        end else if (!pw_blocked && pw_match) begin
          pw_set_q <= 1'b0;
          fail_q <= 3'h0;
        end else if (unlock_err_c && fail_q != pal_pkg::FAIL_MAX) begin
          fail_q <= fail_q + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lock_indication <= 1'b0;
      easy_mode_switch_en <= 1'b1;
      password_registered <= 1'b0;
      fail_count <= 3'h0;
    end else begin
      if (take && lock_ref) begin
        lock_indication <= 1'b1;
      end else if (take && grant) begin
        lock_indication <= 1'b0;
      end
      easy_mode_switch_en <= lwr_ok;
      password_registered <= pw_set_q;
      fail_count <= fail_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the guard
  pw_read_hide_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take && req.op == pal_pkg::OP_READ && req.pnum == pal_pkg::PNUM_PASSWORD && restr
    |=> resp_valid && resp.rdata <= 16'h0005)
    else $error("password read exposed a value above five");

  nolock_pw_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take && req.op == pal_pkg::OP_WRITE && req.pnum == pal_pkg::PNUM_PASSWORD
    && lvl_q == pal_pkg::NO_LOCK |=> resp_valid && !resp.ok && !password_registered)
    else $error("password accepted without a lock level");

  level_four_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take && restr && base == 3'h4 && req.op == pal_pkg::OP_WRITE && !own && !contrast_ok
    |=> resp_valid && !resp.ok && lock_indication && !mem_wr.en)
    else $error("write passed at level four");

  all_clear_run_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take && req.op == pal_pkg::OP_ALL_CLEAR && running_s |=> resp_valid && !resp.ok && !mem_all_clear)
    else $error("all clear performed while running");

  all_clear_unlock_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take && req.op == pal_pkg::OP_ALL_CLEAR && !running_s && !wp_on
    |=> mem_all_clear && lvl_q == pal_pkg::NO_LOCK ##1 !password_registered && fail_count == 3'h0)
    else $error("all clear left the lock in place");

  fail_sat_a: assert property (@(posedge core_clk) disable iff (!resetn)
    fail_q == pal_pkg::FAIL_MAX && !(take && req.op == pal_pkg::OP_ALL_CLEAR)
    |=> fail_q == pal_pkg::FAIL_MAX || !pw_set_q)
    else $error("failure count left saturation");

  unlock_err_a: assert property (@(posedge core_clk) disable iff (!resetn)
    unlock_error |-> pw_set_q && !resp.ok && resp_valid)
    else $error("unlock error without a kept lock");

  easy_mode_a: assert property (@(posedge core_clk) disable iff (!resetn)
    restr && !pal_pkg::LOCAL_WR_MASK[base] |=> !easy_mode_switch_en)
    else $error("easy mode switch left enabled");

  mem_read_lat_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take && mem_read |=> mem_rd_en && !req_ready ##2 resp_valid && req_ready)
    else $error("memory read answer out of step");

  level_frozen_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take && req.op == pal_pkg::OP_WRITE && req.pnum == pal_pkg::PNUM_LOCK_LVL && pw_set_q
    |=> !resp.ok && lock_indication && lvl_q == $past(lvl_q))
    else $error("lock level changed while locked");

  internal_wr_a: assert property (@(posedge core_clk) disable iff (!resetn)
    int_wr.en |=> mem_wr.en && mem_wr.addr == $past(int_wr.addr))
    else $error("internal update was dropped");

endmodule

// file: testbench/param_mem_model.sv
// Behavioural parameter memory facing the access lock.
// Assumes the lock strobes reads and writes on core_clk.
`timescale 1ns/1ps
module param_mem_model (
  // Clock
  input wire logic core_clk,
  // Lock side
  input wire pal_pkg::mem_wr_s mem_wr,
  input wire logic mem_rd_en,
  input wire logic [15:0] mem_raddr,
  output logic [15:0] mem_rdata
);
  logic [15:0] store_q [16];

  // Distinct start values so a wrong address shows
  initial begin
    for (int i = 0; i < 16; i++) begin
      store_q[i] = 16'(i * 16'h1111);
    end
    mem_rdata = 16'h0000;
  end

  // Outside a read the bus toggles, so stale data never passes for an answer
  always @(posedge core_clk) begin
    if (mem_wr.en) store_q[mem_wr.addr[3:0]] <= mem_wr.data;
    if (mem_rd_en) mem_rdata <= store_q[mem_raddr[3:0]];
    else mem_rdata <= ~mem_rdata;
  end
endmodule

// file: testbench/parameter_access_lock_tb_top.sv
// Self-checking bench for the parameter access lock.
// Assumes the memory model answers reads one cycle after the strobe.
`timescale 1ns/1ps
module parameter_access_lock_tb_top;
  localparam pal_pkg::op_e RD = pal_pkg::OP_READ;
  localparam pal_pkg::op_e WR = pal_pkg::OP_WRITE;
  localparam pal_pkg::op_e CLR = pal_pkg::OP_CLEAR;
  localparam pal_pkg::op_e ACLR = pal_pkg::OP_ALL_CLEAR;
  localparam pal_pkg::op_e CPY = pal_pkg::OP_COPY;
  localparam logic [15:0] P_DISP = pal_pkg::PNUM_DISP_SEL;
  localparam logic [15:0] P_LVL = pal_pkg::PNUM_LOCK_LVL;
  localparam logic [15:0] P_PW = pal_pkg::PNUM_PASSWORD;
  localparam logic [15:0] P_ORD = 16'h0010;
  localparam logic [15:0] PW = 16'h04d2;
  localparam logic [15:0] PW_BAD = 16'h0457;
  localparam logic [15:0] NONE = 16'h270f;
  // Bit n set when level n grants the access
  localparam logic [7:0] LOC_RD = 8'h4e;
  localparam logic [7:0] LOC_WR = 8'h48;
  localparam logic [7:0] SER_RD = 8'h2e;
  localparam logic [7:0] SER_WR = 8'h24;

  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic req_valid = 1'h0;
  pal_pkg::req_s req = '0;
  logic req_ready, resp_valid, mem_rd_en, mem_clear, mem_all_clear, mem_copy;
  pal_pkg::resp_s resp, got;
  logic [1:0] write_protect_select = 2'h0;
  logic [15:0] local_command_source_select = 16'h0000;
  logic drive_running = 1'h0;
  logic param_unit_present = 1'h0;
  pal_pkg::mem_wr_s int_wr = '0;
  pal_pkg::mem_wr_s mem_wr;
  logic [15:0] mem_raddr, mem_rdata;
  logic lock_indication, unlock_error, easy_mode_switch_en, password_registered;
  logic [2:0] fail_count;
  logic got_wr, got_ue, got_ac;
  int error_cnt = 0;
  int comparisons = 0;

  ////////////////////////////////////////////////////////////////////////////
  parameter_access_lock u_parameter_access_lock (
    .core_clk(core_clk), .resetn(resetn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp),
    .write_protect_select(write_protect_select), .local_command_source_select(local_command_source_select),
    .drive_running(drive_running), .param_unit_present(param_unit_present), .int_wr(int_wr),
    .mem_wr(mem_wr), .mem_rd_en(mem_rd_en), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata),
    .mem_clear(mem_clear), .mem_all_clear(mem_all_clear), .mem_copy(mem_copy),
    .lock_indication(lock_indication), .unlock_error(unlock_error),
    .easy_mode_switch_en(easy_mode_switch_en), .password_registered(password_registered),
    .fail_count(fail_count)
  );

  param_mem_model u_param_mem_model (
    .core_clk(core_clk), .mem_wr(mem_wr), .mem_rd_en(mem_rd_en), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata)
  );

  // 250 MHz clock
  always #2 core_clk = ~core_clk;

  // Watchdog, well past the expected run of under a thousand cycles
  initial begin
    #200_000;
    error_cnt++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk1(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_sim();
    $display("TB: errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Reset held 16 cycles; pins settle through the synchronisers after release
  task automatic do_reset();
    @(negedge core_clk);
    resetn = 1'h0;
    repeat (16) @(negedge core_clk);
    resetn = 1'h1;
    repeat (3) @(negedge core_clk);
  endtask

  // One request held for one cycle once ready, answer captured and its ok flag compared
  task automatic access(input pal_pkg::op_e op, input logic ser, input logic smp,
                        input logic [15:0] pn, input logic [15:0] wd, input logic eok);
    int n;
    n = 0;
    // Gap edge so req_valid is never lowered and raised in one step
    @(negedge core_clk);
    while (req_ready !== 1'h1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    req_valid = 1'h1;
    req = '{op: op, serial: ser, simple: smp, wp_exempt: 1'h0, pnum: pn, wdata: wd};
    @(negedge core_clk);
    req_valid = 1'h0;
    n = 0;
    while (resp_valid !== 1'h1 && n < 6) begin
      @(negedge core_clk);
      n++;
    end
    chk1(resp_valid, 1'h1);
    got = resp;
    got_wr = mem_wr.en;
    got_ue = unlock_error;
    got_ac = mem_all_clear;
    chk1(got.ok, eok);
  endtask

  task automatic lock_at(input logic [15:0] lvl);
    do_reset();
    access(WR, 1'h0, 1'h0, P_LVL, lvl, 1'h1);
    access(WR, 1'h0, 1'h0, P_PW, PW, 1'h1);
    repeat (2) @(negedge core_clk);
    chk1(password_registered, 1'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_path();
    do_reset();
    chk1(easy_mode_switch_en, 1'h1);
    access(RD, 1'h0, 1'h0, P_PW, 16'h0000, 1'h1);
    chk16(got.rdata, NONE);
    access(WR, 1'h0, 1'h0, P_PW, PW, 1'h0);
    access(RD, 1'h0, 1'h0, P_LVL, 16'h0000, 1'h1);
    chk16(got.rdata, NONE);
    access(WR, 1'h0, 1'h0, P_ORD, 16'habcd, 1'h1);
    chk1(got_wr, 1'h1);
    access(RD, 1'h1, 1'h0, P_ORD, 16'h0000, 1'h1);
    chk16(got.rdata, 16'habcd);
    chk16(mem_raddr, P_ORD);
    chk1(req_ready, 1'h1);
    access(CLR, 1'h0, 1'h0, P_ORD, 16'h0000, 1'h1);
    chk1(mem_clear, 1'h1);
    access(CPY, 1'h0, 1'h0, P_ORD, 16'h0000, 1'h1);
    chk1(mem_copy, 1'h1);
    write_protect_select = 2'h1;
    access(WR, 1'h0, 1'h0, P_ORD, 16'h1111, 1'h0);
    access(CLR, 1'h0, 1'h0, P_ORD, 16'h0000, 1'h0);
    access(WR, 1'h0, 1'h0, P_LVL, 16'h0001, 1'h1);
    write_protect_select = 2'h0;
  endtask

  task automatic t_display();
    do_reset();
    access(WR, 1'h0, 1'h0, P_DISP, NONE, 1'h1);
    access(RD, 1'h0, 1'h0, P_ORD, 16'h0000, 1'h0);
    access(RD, 1'h0, 1'h1, P_ORD, 16'h0000, 1'h1);
    access(RD, 1'h1, 1'h0, P_ORD, 16'h0000, 1'h1);
    access(WR, 1'h0, 1'h0, P_LVL, 16'h0001, 1'h0);
    local_command_source_select = 16'h0002;
    access(RD, 1'h1, 1'h0, P_ORD, 16'h0000, 1'h0);
    local_command_source_select = 16'h0000;
  endtask

  // Every level, low and high form, from both ports
  task automatic t_levels();
    logic [15:0] lvl;
    int n;
    for (int i = 0; i < 12; i++) begin
      n = i % 6 + 1;
      lvl = (i < 6) ? 16'(n) : 16'(n + 100);
      lock_at(lvl);
      chk1(easy_mode_switch_en, LOC_WR[n]);
      access(WR, 1'h0, 1'h0, P_ORD, 16'h2222, LOC_WR[n]);
      chk1(got.lock_refused, ~LOC_WR[n]);
      @(negedge core_clk);
      chk1(lock_indication, ~LOC_WR[n]);
      access(RD, 1'h0, 1'h0, P_ORD, 16'h0000, LOC_RD[n]);
      access(WR, 1'h1, 1'h0, P_ORD, 16'h3333, SER_WR[n]);
      access(RD, 1'h1, 1'h0, P_ORD, 16'h0000, SER_RD[n]);
      access(RD, 1'h0, 1'h0, P_PW, 16'h0000, 1'h1);
      chk16(got.rdata, 16'h0000);
      access(RD, 1'h0, 1'h0, P_LVL, 16'h0000, 1'h1);
      chk16(got.rdata, lvl);
      access(WR, 1'h0, 1'h0, P_LVL, 16'h0003, 1'h0);
      access(CLR, 1'h0, 1'h0, P_ORD, 16'h0000, 1'h0);
      chk1(mem_clear, 1'h0);
      access(CPY, 1'h0, 1'h0, P_ORD, 16'h0000, 1'h0);
      chk1(mem_copy, 1'h0);
    end
  endtask

  // A miss counts at every level but reads back only at high levels; a match unlocks and clears the count
  task automatic t_unlock(input logic [15:0] lvl);
    lock_at(lvl);
    access(WR, 1'h0, 1'h0, P_PW, PW_BAD, 1'h0);
    chk1(got_ue, 1'h1);
    repeat (2) @(negedge core_clk);
    access(RD, 1'h0, 1'h0, P_PW, 16'h0000, 1'h1);
    chk16(got.rdata, (lvl > 16'h0064) ? 16'h0001 : 16'h0000);
    access(WR, 1'h0, 1'h0, P_PW, PW, 1'h1);
    repeat (2) @(negedge core_clk);
    chk1(password_registered, 1'h0);
    chk16({13'h0000, fail_count}, 16'h0000);
  endtask

  task automatic t_saturate();
    lock_at(16'h0067);
    repeat (5) access(WR, 1'h0, 1'h0, P_PW, PW_BAD, 1'h0);
    // Sixth miss is swallowed: answered ok, no error, no count
    access(WR, 1'h0, 1'h0, P_PW, PW_BAD, 1'h1);
    chk1(got_ue, 1'h0);
    repeat (2) @(negedge core_clk);
    chk16({13'h0000, fail_count}, 16'h0005);
    access(RD, 1'h1, 1'h0, P_PW, 16'h0000, 1'h1);
    chk16(got.rdata, 16'h0005);
    access(WR, 1'h0, 1'h0, P_PW, PW, 1'h1);
    repeat (2) @(negedge core_clk);
    chk1(password_registered, 1'h1);
    drive_running = 1'h1;
    repeat (3) @(negedge core_clk);
    access(ACLR, 1'h0, 1'h0, P_ORD, 16'h0000, 1'h0);
    chk1(got_ac, 1'h0);
    drive_running = 1'h0;
    repeat (3) @(negedge core_clk);
    access(ACLR, 1'h0, 1'h0, P_ORD, 16'h0000, 1'h1);
    chk1(got_ac, 1'h1);
    repeat (2) @(negedge core_clk);
    chk1(password_registered, 1'h0);
    chk16({13'h0000, fail_count}, 16'h0000);
    access(RD, 1'h0, 1'h0, P_LVL, 16'h0000, 1'h1);
    chk16(got.rdata, NONE);
  endtask

  // Full lock at level 4: own updates and contrast still pass
  task automatic t_internal();
    do_reset();
    access(WR, 1'h0, 1'h0, P_LVL, 16'h0004, 1'h1);
    access(WR, 1'h0, 1'h0, P_PW, 16'h03e7, 1'h0);
    access(WR, 1'h0, 1'h0, P_PW, PW, 1'h1);
    int_wr = '{en: 1'h1, addr: 16'h0005, data: 16'h5555};
    @(negedge core_clk);
    int_wr = '0;
    chk1(mem_wr.en, 1'h1);
    chk16(mem_wr.data, 16'h5555);
    param_unit_present = 1'h1;
    repeat (3) @(negedge core_clk);
    access(WR, 1'h0, 1'h1, pal_pkg::PNUM_CONTRAST, 16'h0007, 1'h1);
    access(RD, 1'h0, 1'h1, pal_pkg::PNUM_CONTRAST, 16'h0000, 1'h1);
    chk16(got.rdata, 16'h0007);
    access(RD, 1'h0, 1'h1, P_ORD, 16'h0000, 1'h0);
    param_unit_present = 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    t_reset_path();
    t_display();
    t_levels();
    t_unlock(16'h0001);
    t_unlock(16'h0065);
    t_saturate();
    t_internal();
    end_sim();
  end
endmodule
